// ===== src/ccg_pkg.sv
package ccg_pkg;
  localparam logic [7:0] SEL_RESET      = 8'h04;
  localparam int         DIV_LSB        = 0;
  localparam int         DIV_W          = 3;
  localparam logic [2:0] DIV_MAX_CODE   = 3'h4;
  localparam int         STAB_EXP       = 17;
  localparam int         STAB_CYCLES    = 2 ** STAB_EXP;
  localparam int         SWITCH_MAX_EXP = 4;
endpackage

// ===== src/ccg_divider.sv
`timescale 1ns/1ps
// free running power-of-two divider; emits one-cycle enables at the end of each period
module ccg_divider #(
  parameter int W = 4
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         run_in,
  input  wire logic [2:0]   sel_in,
  output logic              tick_out,
  output logic [W-1:0]      count_out
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] mask;
  assign mask = W'((1 << sel_in) - 1);
  // tick when all selected low bits are ones: end of an output period
  assign tick_out = run_in && ((cnt_r & mask) == mask);
  assign count_out = cnt_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
    end else if (run_in) begin
      cnt_r <= cnt_r + W'(1);
    end
  end
endmodule

// ===== src/ccg_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - reset loads select register with 04h: slowest main clock speed
// - divider bits 2:0 pick fx, fx/2, fx/4, fx/8, fx/16; others prohibited
// - select register takes single-bit and whole-byte writes
// - after a write the old clock runs some instructions before switching
// - delay at most one old-clock period: 1,2,4,8,16 fx cycles leaving fx..fx/16
// - oscillator stays stopped while reset is low
// - after reset wait 2^17 main clocks, then CPU runs at slowest speed
// - stop instruction or control bit halts the oscillator
// - stop and halt standby modes exist on the main clock
// - block makes main, cpu and peripheral clocks and controls standby
module ccg_top #(
  parameter int STAB_CYCLES = ccg_pkg::STAB_CYCLES
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       wr_byte_in,
  input  wire logic       wr_bit_in,
  input  wire logic [2:0] bit_idx_in,
  input  wire logic       bit_val_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       stop_req_in,
  input  wire logic       halt_req_in,
  input  wire logic       osc_stop_in,
  input  wire logic       wake_in,
  output logic [7:0]      cpu_clock_select_out,
  output logic            osc_run_out,
  output logic            cpu_clk_en_out,
  output logic            periph_clk_en_out,
  output logic            cpu_run_out,
  output logic            standby_out
);
  typedef enum logic [1:0] {ST_STAB, ST_RUN, ST_HALT, ST_STOP} ccg_state_t;
  ccg_state_t  state_r, state_nxt;
  logic [7:0]  sel_r;
  logic [2:0]  div_act_r;
  logic        pend_r;
  logic [17:0] stab_r;
  logic        tick;
  logic [3:0]  cnt;
  logic [7:0]  sel_nxt;
  logic        write;
  logic        osc_on;
  logic        stab_done;
  logic        sel_legal;

  assign osc_on = (state_r != ST_STOP);
  assign write  = wr_byte_in || wr_bit_in;
  // bit manipulation edits one bit of the stored byte
  assign sel_nxt = wr_byte_in ? wdata_in :
                   (sel_r & ~(8'h01 << bit_idx_in)) | ({7'h00, bit_val_in} << bit_idx_in);
  assign stab_done = (stab_r == 18'(STAB_CYCLES - 1));
  // prohibited codes are stored for read back but never reach the divider
  assign sel_legal = (sel_nxt[2:0] <= ccg_pkg::DIV_MAX_CODE);

  ccg_divider #(.W(ccg_pkg::SWITCH_MAX_EXP)) u_div (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .run_in    (osc_on),
    .sel_in    (div_act_r),
    .tick_out  (tick),
    .count_out (cnt)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_STAB: if (stab_done) state_nxt = ST_RUN;
      ST_RUN: begin
        if (stop_req_in || osc_stop_in) state_nxt = ST_STOP;
        else if (halt_req_in) state_nxt = ST_HALT;
      end
      ST_HALT: if (wake_in) state_nxt = ST_RUN;
      ST_STOP: if (wake_in) state_nxt = ST_STAB;                     // restart needs stabilising
    endcase
  end

  // oscillator held off throughout reset; counting restarts at release
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= ST_STAB;
      stab_r  <= '0;
    end else begin
      state_r <= state_nxt;
      stab_r  <= (state_r == ST_STAB) ? stab_r + 18'h1 : 18'h0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sel_r <= ccg_pkg::SEL_RESET;
    end else if (write && state_r == ST_RUN) begin
      sel_r <= sel_nxt;
    end
  end

  // a pending ratio is adopted only at the end of an old-clock period, which
  // bounds the delay to one old-clock period: 1/2/4/8/16 fast-clock units leaving fx..fx/16
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_act_r <= ccg_pkg::SEL_RESET[2:0];
      pend_r    <= 1'b0;
    end else if (write && state_r == ST_RUN) begin
      // a legal write in the adopting cycle re-arms with its own code, so it is never lost
      pend_r <= sel_legal;
      if (pend_r && tick) begin
        div_act_r <= sel_r[2:0];
      end
    end else if (pend_r && tick) begin
      div_act_r <= sel_r[2:0];
      pend_r    <= 1'b0;
    end
  end

  // outputs registered; peripherals keep their clock during halt
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cpu_clock_select_out <= ccg_pkg::SEL_RESET;
      osc_run_out          <= 1'b0;
      cpu_clk_en_out       <= 1'b0;
      periph_clk_en_out    <= 1'b0;
      cpu_run_out          <= 1'b0;
      standby_out          <= 1'b0;
    end else begin
      cpu_clock_select_out <= sel_r;
      osc_run_out          <= osc_on;
      cpu_clk_en_out       <= tick && state_r == ST_RUN;
      periph_clk_en_out    <= osc_on && state_r != ST_STAB;
      cpu_run_out          <= state_r == ST_RUN;
      standby_out          <= state_r == ST_HALT || state_r == ST_STOP;
    end
  end

  // reset and stabilisation
  AST_RESET_SLOW: assert property (
    @(posedge clk_in) $rose(rst_n_in) |-> sel_r == 8'h04)
    else $error("select not 04h after reset");

  AST_OSC_RESET: assert property (
    @(posedge clk_in) !rst_n_in |-> !osc_run_out)
    else $error("oscillator runs in reset");

  AST_NO_RUN_STAB: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_r == ST_STAB |-> !cpu_run_out || $past(state_r) == ST_RUN)
    else $error("cpu runs during stabilisation");

  AST_STAB_LEN: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_r == ST_STAB && stab_r < 18'(STAB_CYCLES - 1)) |=> state_r == ST_STAB)
    else $error("stabilisation ended early");

  AST_STAB_EXIT: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_r == ST_STAB && stab_done) |=> state_r == ST_RUN)
    else $error("stabilisation did not end");

  AST_STAB_NO_CPU_CLK: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_r == ST_STAB |=> !cpu_clk_en_out)
    else $error("cpu clock during stabilisation");

  AST_STAB_NO_PERIPH: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_r == ST_STAB |=> !periph_clk_en_out)
    else $error("peripheral clock during stabilisation");

  AST_STAB_ENTRY: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (state_r == ST_STOP && wake_in) |=> state_r == ST_STAB)
    else $error("stop release skipped stabilisation");

  // standby modes and oscillator
  AST_STOP_OSC: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_r == ST_STOP |=> !osc_run_out)
    else $error("oscillator runs in stop");

  AST_OSC_FOLLOW: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_r != ST_STOP |=> osc_run_out)
    else $error("oscillator off outside stop");

  AST_HALT_CPU: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_r == ST_HALT |=> !cpu_clk_en_out && standby_out)
    else $error("cpu clock in halt");

  AST_STOP_STANDBY: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_r == ST_STOP |=> standby_out && !cpu_run_out)
    else $error("stop not flagged as standby");

  AST_HALT_PERIPH: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_r == ST_HALT |=> periph_clk_en_out)
    else $error("peripheral clock lost in halt");

  AST_RUN_FLAG: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    state_r == ST_RUN |=> cpu_run_out && !standby_out)
    else $error("run state not flagged");

  AST_EN_ON_TICK: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    cpu_clk_en_out |-> $past(tick))
    else $error("cpu clock pulse off divider tick");

  // select register writes
  AST_BYTE_WRITE: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_byte_in && state_r == ST_RUN) |=> sel_r == $past(wdata_in))
    else $error("byte write not stored");

  AST_BIT_WRITE: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (wr_bit_in && !wr_byte_in && state_r == ST_RUN) |=>
    sel_r[$past(bit_idx_in)] == $past(bit_val_in))
    else $error("bit write not stored");

  AST_WRITE_HOLD: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    !(write && state_r == ST_RUN) |=> sel_r == $past(sel_r))
    else $error("select changed without write");

  AST_SEL_OUT_COPY: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> cpu_clock_select_out == $past(sel_r))
    else $error("select output not a copy");

  // divider switchover
  AST_SWITCH_BOUND: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    $rose(pend_r) |-> ##[1:17] !pend_r)
    else $error("switchover too slow");

  AST_SWITCH_EDGE: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    div_act_r != $past(div_act_r) |-> $past(tick))
    else $error("switch off boundary");

  AST_LEGAL_DIV: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    div_act_r <= 3'h4)
    else $error("illegal divider active");

  AST_ILLEGAL_KEEP: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (write && state_r == ST_RUN && !sel_legal) |=> !pend_r)
    else $error("prohibited code armed a switch");

  AST_OLD_CLOCK: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (pend_r && !tick) |=> div_act_r == $past(div_act_r))
    else $error("early switch");

  COV_SWITCH:     cover property (@(posedge clk_in) $fell(pend_r));
  COV_HALT:       cover property (@(posedge clk_in) state_r == ST_HALT);
  COV_STOP:       cover property (@(posedge clk_in) state_r == ST_STOP ##1 state_r == ST_STAB);
  COV_FULL_SPEED: cover property (@(posedge clk_in) div_act_r == 3'h0);
  COV_BIT_WRITE:  cover property (@(posedge clk_in) wr_bit_in && state_r == ST_RUN);
endmodule

// ===== testbench/ccg_cpu_model.sv
`timescale 1ns/1ps
// stands in for the cpu core: times the gap between clock-enable pulses
module ccg_cpu_model (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic cpu_clk_en_in,
  output int        period_out,
  output int        pulses_out
);
  int gap_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_r <= 1;
      period_out <= 0;
      pulses_out <= 0;
    end else if (cpu_clk_en_in) begin
      period_out <= gap_r;
      pulses_out <= pulses_out + 1;
      gap_r <= 1;
    end else begin
      gap_r <= gap_r + 1;
    end
  end
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       wr_byte_in = 1'b0;
  logic       wr_bit_in = 1'b0;
  logic [2:0] bit_idx_in = 3'h0;
  logic       bit_val_in = 1'b0;
  logic [7:0] wdata_in = 8'h00;
  logic [3:0] req_r = 4'h0;
  logic [7:0] sel;
  logic       osc_run, cpu_en, per_en, cpu_run, standby;
  int         errors = 0, comparisons = 0, cyc = 0, period, pulses, p0, i;
  always #20 clk_in = ~clk_in;
  // short stabilisation so the restart paths fit the run
  ccg_top #(.STAB_CYCLES(16)) ccg_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .wr_byte_in(wr_byte_in), .wr_bit_in(wr_bit_in), .bit_idx_in(bit_idx_in),
    .bit_val_in(bit_val_in), .wdata_in(wdata_in), .stop_req_in(req_r[1]),
    .halt_req_in(req_r[0]), .osc_stop_in(req_r[2]), .wake_in(req_r[3]),
    .cpu_clock_select_out(sel), .osc_run_out(osc_run), .cpu_clk_en_out(cpu_en),
    .periph_clk_en_out(per_en), .cpu_run_out(cpu_run), .standby_out(standby));
  ccg_cpu_model ccg_cpu_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .cpu_clk_en_in(cpu_en), .period_out(period), .pulses_out(pulses));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr_byte(input logic [7:0] d);
    @(posedge clk_in);
    wr_byte_in <= 1'b1;
    wdata_in <= d;
    @(posedge clk_in);
    wr_byte_in <= 1'b0;
    tick(1);
  endtask
  // one-cycle strobe: bit 0 halt, 1 stop, 2 oscillator stop, 3 wake
  task automatic strobe(input int k);
    @(posedge clk_in);
    req_r <= 4'h1 << k;
    @(posedge clk_in);
    req_r <= 4'h0;
    tick(3);
  endtask
  task automatic wait_run;
    for (i = 0; i < 60 && cpu_run !== 1'b1; i++) tick(1);
    chk("cpu running", 8'h01, {7'h00, cpu_run});
    chk("osc running", 8'h01, {7'h00, osc_run});
    chk("periph clock on", 8'h01, {7'h00, per_en});
  endtask
  // three pulses settle past any switchover before the gap is judged
  task automatic meas(input logic [7:0] exp);
    p0 = pulses;
    for (i = 0; i < 120 && pulses < p0 + 3; i++) tick(1);
    chk("cpu clock period", exp, period[7:0]);
  endtask
  task automatic t_reset;
    tick(2);
    chk("select in reset", 8'h04, sel);
    chk("osc in reset", 8'h00, {7'h00, osc_run});
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    tick(8);
    chk("cpu run early", 8'h00, {7'h00, cpu_run});
    wait_run();
    meas(8'h10);
  endtask
  task automatic t_div;
    // software keeps bits 3 to 7 zero
    // speed is raised only once the supply has settled after stabilisation
    for (int c = 3; c >= 0; c--) begin
      wr_byte(8'(c));
      chk("select byte", 8'(c), sel);
      meas(8'h01 << c);
    end
    @(posedge clk_in);
    wr_bit_in <= 1'b1;
    bit_idx_in <= 3'h2;
    bit_val_in <= 1'b1;
    @(posedge clk_in);
    wr_bit_in <= 1'b0;
    tick(1);
    chk("select bit", 8'h04, sel);
    meas(8'h10);
    wr_byte(8'h05);
    chk("select prohibited", 8'h05, sel);
    meas(8'h10);
  endtask
  task automatic t_standby;
    strobe(0);
    chk("halt standby", 8'h01, {7'h00, standby});
    p0 = pulses;
    tick(40);
    chk("pulses in halt", 8'h00, 8'(pulses - p0));
    strobe(3);
    wait_run();
    // stop is only used with a resonator, never an external clock
    for (int k = 1; k <= 2; k++) begin
      strobe(k);
      chk("osc stopped", 8'h00, {7'h00, osc_run});
      chk("periph clock off", 8'h00, {7'h00, per_en});
      strobe(3);
      chk("cpu run restab", 8'h00, {7'h00, cpu_run});
      wait_run();
    end
  endtask
  initial begin
    t_reset();
    t_div();
    t_standby();
    wrap_up();
  end
endmodule
